// >>> fpt_sequencer.sv
// Flash program/erase timing sequencer with one fixed slot length per phase
`timescale 1ns/1ps
`include "fpt_cfg.svh"
// Overview of operation
// - A word or byte program lasts 35 timing generator periods from start to end.
// - The first word of a block program occupies 30 timing generator periods.
// - Each of up to 63 further words of a block occupies 21 timing generator periods.
// - A block program closes with a 6-period end-sequence wait before completion.
// - A mass erase lasts 5297 timing generator periods.
// - A segment erase lasts 4819 periods; all counts are fixed and count generator periods.
module fpt_sequencer #(
	parameter int GEN_DIV = `FPT_GEN_DIV
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic OP_REQ,
	input fpt_pkg::fpt_cmd_type OP_CMD,
	output logic BUSY,
	output logic DONE,
	output logic REQ_IGNORED,
	output fpt_pkg::fpt_array_type ARRAY_CTRL,
	output logic WORD_STROBE,
	output logic [`FPT_IDX_W-1:0] WORD_IDX
);
	import fpt_pkg::*;

	if (GEN_DIV < 1) begin : g_bad_div
		$error("fpt_sequencer: GEN_DIV must be at least 1");
	end

	fpt_state_type state;
	fpt_state_type next_state;
	logic [`FPT_TICK_W-1:0] tick_cnt;
	logic [`FPT_TICK_W-1:0] slot_len;
	logic [`FPT_IDX_W-1:0] last_idx;
	logic [`FPT_IDX_W-1:0] next_idx;
	logic tick;
	logic slot_end;
	logic next_strobe;
	logic next_done;
	logic accept;

	fpt_tick_gen #(
		.DIV(GEN_DIV)
	) u_tick (
		.clk(CLK),
		.rst(SYS_RST),
		.run(state != FPT_S_IDLE),
		.tick(tick)
	);

	// Slot lengths are hardwired per phase, in generator periods
	always_comb begin
		case (state)
			FPT_S_WORD: slot_len = `FPT_TICKS_WORD;
			FPT_S_BLK_FIRST: slot_len = `FPT_TICKS_BLK_FIRST;
			FPT_S_BLK_NEXT: slot_len = `FPT_TICKS_BLK_NEXT;
			FPT_S_BLK_END: slot_len = `FPT_TICKS_BLK_END;
			FPT_S_MASS: slot_len = `FPT_TICKS_MASS;
			FPT_S_SEG: slot_len = `FPT_TICKS_SEG;
			default: slot_len = `FPT_TICK_ONE;
		endcase
	end

	assign slot_end = tick && (tick_cnt == slot_len - `FPT_TICK_ONE);
	assign accept = OP_REQ && (state == FPT_S_IDLE);

	always_comb begin
		next_state = state;
		next_idx = WORD_IDX;
		next_strobe = 1'b0;
		next_done = 1'b0;
		case (state)
			FPT_S_IDLE: begin
				if (OP_REQ) begin
					next_idx = `FPT_IDX_ZERO;
					case (OP_CMD.op)
						FPT_OP_WORD: begin
							next_state = FPT_S_WORD;
							next_strobe = 1'b1;
						end
						FPT_OP_BLOCK: begin
							next_state = FPT_S_BLK_FIRST;
							next_strobe = 1'b1;
						end
						FPT_OP_SEG_ERASE: next_state = FPT_S_SEG;
						default: next_state = FPT_S_MASS;
					endcase
				end
			end
			FPT_S_WORD, FPT_S_SEG, FPT_S_MASS, FPT_S_BLK_END: begin
				if (slot_end) begin
					next_state = FPT_S_IDLE;
					next_done = 1'b1;
				end
			end
			FPT_S_BLK_FIRST: begin
				if (slot_end) begin
					if (last_idx == `FPT_IDX_ZERO) begin
						next_state = FPT_S_BLK_END;
					end else begin
						next_state = FPT_S_BLK_NEXT;
						next_idx = WORD_IDX + `FPT_IDX_ONE;
						next_strobe = 1'b1;
					end
				end
			end
			FPT_S_BLK_NEXT: begin
				if (slot_end) begin
					if (WORD_IDX == last_idx) begin
						next_state = FPT_S_BLK_END;
					end else begin
						next_idx = WORD_IDX + `FPT_IDX_ONE;
						next_strobe = 1'b1;
					end
				end
			end
			default: next_state = FPT_S_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state <= FPT_S_IDLE;
			BUSY <= 1'b0;
		end else begin
			state <= next_state;
			BUSY <= (next_state != FPT_S_IDLE);
		end
	end

	// Period count inside the current slot; restarts at every slot boundary
	always_ff @(posedge CLK) begin
		if (SYS_RST || slot_end || state == FPT_S_IDLE) begin
			tick_cnt <= '0;
		end else if (tick) begin
			tick_cnt <= tick_cnt + `FPT_TICK_ONE;
		end
	end

	// Block length is latched at start; later command changes cannot stretch a block
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			last_idx <= `FPT_IDX_ZERO;
		end else if (accept) begin
			last_idx <= OP_CMD.last_idx;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			WORD_IDX <= `FPT_IDX_ZERO;
			WORD_STROBE <= 1'b0;
			DONE <= 1'b0;
			REQ_IGNORED <= 1'b0;
		end else begin
			WORD_IDX <= next_idx;
			WORD_STROBE <= next_strobe;
			DONE <= next_done;
			REQ_IGNORED <= OP_REQ && (state != FPT_S_IDLE);
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ARRAY_CTRL <= '0;
		end else begin
			ARRAY_CTRL.prog_en <= (next_state == FPT_S_WORD) || (next_state == FPT_S_BLK_FIRST)
				|| (next_state == FPT_S_BLK_NEXT);
			ARRAY_CTRL.erase_en <= (next_state == FPT_S_SEG) || (next_state == FPT_S_MASS);
			ARRAY_CTRL.mass_en <= (next_state == FPT_S_MASS);
		end
	end

	// Checking helpers: cycles since operation start and since slot start
	int chk_op_cycles;
	int chk_slot_cycles;
	int chk_words;
	fpt_op_type chk_op;
	localparam int D = GEN_DIV;
	localparam int T_WORD = int'(`FPT_TICKS_WORD) * D;
	localparam int T_BLK_FIRST = int'(`FPT_TICKS_BLK_FIRST) * D;
	localparam int T_BLK_NEXT = int'(`FPT_TICKS_BLK_NEXT) * D;
	localparam int T_BLK_END = int'(`FPT_TICKS_BLK_END) * D;
	localparam int T_MASS = int'(`FPT_TICKS_MASS) * D;
	localparam int T_SEG = int'(`FPT_TICKS_SEG) * D;

	// Strobes counted apart from the index, so a lost or doubled word slot shows up
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			chk_words <= 0;
		end else if (accept) begin
			chk_words <= int'(next_strobe);
		end else if (next_strobe) begin
			chk_words <= chk_words + 1;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST || accept) begin
			chk_op_cycles <= 0;
		end else if (state != FPT_S_IDLE) begin
			chk_op_cycles <= chk_op_cycles + 1;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST || state != next_state || next_strobe) begin
			chk_slot_cycles <= 0;
		end else begin
			chk_slot_cycles <= chk_slot_cycles + 1;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			chk_op <= FPT_OP_WORD;
		end else if (accept) begin
			chk_op <= OP_CMD.op;
		end
	end

	AST_WORD_TIME: assert property (@(posedge CLK) disable iff (SYS_RST)
		(state == FPT_S_WORD && next_state == FPT_S_IDLE) |-> chk_op_cycles == T_WORD - 1)
		else $error("word program length wrong");
	AST_BLK_FIRST: assert property (@(posedge CLK) disable iff (SYS_RST)
		(state == FPT_S_BLK_FIRST && next_state != FPT_S_BLK_FIRST) |-> chk_slot_cycles == T_BLK_FIRST - 1)
		else $error("first block word length wrong");
	AST_BLK_NEXT: assert property (@(posedge CLK) disable iff (SYS_RST)
		(state == FPT_S_BLK_NEXT && (next_strobe || next_state != state)) |-> chk_slot_cycles == T_BLK_NEXT - 1)
		else $error("further block word length wrong");
	AST_BLK_COUNT: assert property (@(posedge CLK) disable iff (SYS_RST)
		((state == FPT_S_BLK_FIRST || state == FPT_S_BLK_NEXT) && next_state == FPT_S_BLK_END)
		|-> WORD_IDX == last_idx && chk_words == int'(last_idx) + 1)
		else $error("block word count wrong");
	AST_BLK_END: assert property (@(posedge CLK) disable iff (SYS_RST)
		(state == FPT_S_BLK_END && next_state == FPT_S_IDLE) |-> chk_slot_cycles == T_BLK_END - 1 ##1 DONE)
		else $error("block end wait wrong");
	AST_MASS_TIME: assert property (@(posedge CLK) disable iff (SYS_RST)
		$fell(BUSY) && chk_op == FPT_OP_MASS_ERASE |-> chk_op_cycles == T_MASS && DONE)
		else $error("mass erase length wrong");
	AST_SEG_TIME: assert property (@(posedge CLK) disable iff (SYS_RST)
		$fell(BUSY) && chk_op == FPT_OP_SEG_ERASE |-> chk_op_cycles == T_SEG && ARRAY_CTRL == '0)
		else $error("segment erase length wrong");
	AST_BUSY_HOLD: assert property (@(posedge CLK) disable iff (SYS_RST)
		accept |=> BUSY throughout (!DONE [*2]))
		else $error("busy not held after start");
	AST_IGNORE: assert property (@(posedge CLK) disable iff (SYS_RST)
		(OP_REQ && state != FPT_S_IDLE && !slot_end) |=> REQ_IGNORED && $stable(last_idx) && BUSY)
		else $error("request during sequence not ignored");

	COV_WORD: cover property (@(posedge CLK) disable iff (SYS_RST) $fell(BUSY) && chk_op == FPT_OP_WORD);
	COV_BLOCK_MULTI: cover property (@(posedge CLK) disable iff (SYS_RST)
		state == FPT_S_BLK_NEXT && next_state == FPT_S_BLK_END);
	COV_SEG: cover property (@(posedge CLK) disable iff (SYS_RST) $fell(BUSY) && chk_op == FPT_OP_SEG_ERASE);
	COV_IGNORED: cover property (@(posedge CLK) disable iff (SYS_RST) REQ_IGNORED);
endmodule

// >>> fpt_cfg.svh
// Constants for the flash program/erase timing sequencer
`ifndef FPT_CFG_SVH
`define FPT_CFG_SVH
`define FPT_CLK_PERIOD_NS 4
`define FPT_CLK_KHZ (1000000 / `FPT_CLK_PERIOD_NS)
`define FPT_GEN_KHZ_MAX 476
`define FPT_GEN_KHZ_MIN 257
`define FPT_GEN_DIV ((`FPT_CLK_KHZ + `FPT_GEN_KHZ_MAX - 1) / `FPT_GEN_KHZ_MAX)
`define FPT_TICK_W 13
`define FPT_IDX_W 6
`define FPT_TICKS_WORD 13'h023
`define FPT_TICKS_BLK_FIRST 13'h01e
`define FPT_TICKS_BLK_NEXT 13'h015
`define FPT_TICKS_BLK_END 13'h006
`define FPT_TICKS_MASS 13'h14b1
`define FPT_TICKS_SEG 13'h12d3
`define FPT_TICK_ONE 13'h001
`define FPT_IDX_ONE 6'h01
`define FPT_IDX_ZERO 6'h00
`endif

// >>> fpt_pkg.sv
// Types shared by the flash program/erase timing sequencer
package fpt_pkg;
	typedef enum logic [1:0] {
		FPT_OP_WORD = 2'h0,
		FPT_OP_BLOCK = 2'h1,
		FPT_OP_SEG_ERASE = 2'h2,
		FPT_OP_MASS_ERASE = 2'h3
	} fpt_op_type;

	typedef enum logic [6:0] {
		FPT_S_IDLE = 7'h01,
		FPT_S_WORD = 7'h02,
		FPT_S_BLK_FIRST = 7'h04,
		FPT_S_BLK_NEXT = 7'h08,
		FPT_S_BLK_END = 7'h10,
		FPT_S_SEG = 7'h20,
		FPT_S_MASS = 7'h40
	} fpt_state_type;

	typedef struct packed {
		fpt_op_type op;
		logic [5:0] last_idx;
	} fpt_cmd_type;

	typedef struct packed {
		logic prog_en;
		logic erase_en;
		logic mass_en;
	} fpt_array_type;
endpackage

// >>> fpt_tick_gen.sv
// Flash timing generator: one-cycle tick every DIV clocks while running
`timescale 1ns/1ps
`include "fpt_cfg.svh"
module fpt_tick_gen #(
	parameter int DIV = `FPT_GEN_DIV
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	output logic tick
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] ONE = CW'(1);
	logic [CW-1:0] cnt;

	if (DIV < 1) begin : g_bad_div
		$error("fpt_tick_gen: DIV must be at least 1");
	end

	// Phase restarts at zero whenever the sequencer goes idle, so every operation
	// lasts an exact multiple of DIV clocks.
	always_ff @(posedge clk) begin
		if (rst || !run || cnt == LAST) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + ONE;
		end
	end

	assign tick = run && (cnt == LAST);
endmodule

// >>> fpt_flash_model.sv
// Behavioural flash array seen from the sequencer's control outputs
`timescale 1ns/1ps
module fpt_flash_model (
	input wire logic clk,
	input wire logic rst,
	input fpt_pkg::fpt_array_type ctrl,
	input wire logic strobe,
	output int words,
	output int prog_time,
	output int mass_time
);
	import fpt_pkg::*;
	// Tallies let software-side budgets be judged; the array itself enforces none
	always_ff @(posedge clk) begin
		if (rst) begin
			words <= 0;
			prog_time <= 0;
			mass_time <= 0;
		end else begin
			words <= words + int'(strobe === 1'b1);
			prog_time <= prog_time + int'(ctrl.prog_en === 1'b1);
			mass_time <= mass_time + int'(ctrl.mass_en === 1'b1);
		end
	end
endmodule

// >>> test_flash_program_erase_timer.sv
// Self-checking bench for the flash program/erase timing sequencer
`timescale 1ns/1ps
module test_flash_program_erase_timer;
	import fpt_pkg::*;
	localparam int D = 2;
	logic CLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic OP_REQ = 1'b0;
	fpt_cmd_type OP_CMD = '0;
	logic BUSY, DONE, REQ_IGNORED, WORD_STROBE;
	fpt_array_type ARRAY_CTRL;
	logic [5:0] WORD_IDX;
	logic [5:0] widx;
	logic done_end;
	int words, prog_time, mass_time;
	int mismatches = 0;
	int checks = 0;
	int len, ecyc, ign, w0, p0, m0;

	fpt_sequencer #(.GEN_DIV(D)) dut (.CLK(CLK), .SYS_RST(SYS_RST), .OP_REQ(OP_REQ), .OP_CMD(OP_CMD),
		.BUSY(BUSY), .DONE(DONE), .REQ_IGNORED(REQ_IGNORED), .ARRAY_CTRL(ARRAY_CTRL),
		.WORD_STROBE(WORD_STROBE), .WORD_IDX(WORD_IDX));
	fpt_flash_model array (.clk(CLK), .rst(SYS_RST), .ctrl(ARRAY_CTRL), .strobe(WORD_STROBE),
		.words(words), .prog_time(prog_time), .mass_time(mass_time));

	initial begin
		forever #2 CLK = ~CLK;
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic results();
		$display("Checks %0d, mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Poke raises a second request three cycles into the sequence
	task automatic run_op(input fpt_op_type op, input logic [5:0] last, input bit poke);
		int g;
		@(posedge CLK);
		OP_REQ <= 1'b1;
		OP_CMD <= '{op: op, last_idx: last};
		@(posedge CLK);
		OP_REQ <= 1'b0;
		@(negedge CLK);
		len = 0;
		ecyc = 0;
		ign = 0;
		w0 = words;
		p0 = prog_time;
		m0 = mass_time;
		for (g = 0; g < 20000 && BUSY === 1'b1; g++) begin
			len++;
			ecyc += int'(ARRAY_CTRL.erase_en === 1'b1);
			ign += int'(REQ_IGNORED === 1'b1);
			@(posedge CLK);
			OP_REQ <= poke && len == 3;
			@(negedge CLK);
		end
		done_end = DONE;
		widx = WORD_IDX;
	endtask

	task automatic t_word();
		run_op(FPT_OP_WORD, 6'h00, 1'b1);
		chk("word busy", 16'(35 * D), 16'(len));
		chk("word prog", 16'(35 * D), 16'(prog_time - p0));
		chk("word ignored", 16'h0001, 16'(ign));
		chk("word done", 16'h0001, {15'h0000, done_end});
	endtask

	task automatic t_block(input int n);
		run_op(FPT_OP_BLOCK, 6'(n - 1), 1'b0);
		chk("block busy", 16'((36 + 21 * (n - 1)) * D), 16'(len));
		chk("block prog", 16'((30 + 21 * (n - 1)) * D), 16'(prog_time - p0));
		chk("block words", 16'(n), 16'(words - w0));
		chk("block idx", 16'(n - 1), {10'h000, widx});
		chk("block done", 16'h0001, {15'h0000, done_end});
	endtask

	task automatic t_seg();
		run_op(FPT_OP_SEG_ERASE, 6'h00, 1'b0);
		chk("seg busy", 16'(4819 * D), 16'(len));
		chk("seg erase", 16'(4819 * D), 16'(ecyc));
		chk("seg mass", 16'h0000, 16'(mass_time - m0));
	endtask

	task automatic t_mass();
		run_op(FPT_OP_MASS_ERASE, 6'h00, 1'b1);
		chk("mass busy", 16'(5297 * D), 16'(len));
		chk("mass level", 16'(5297 * D), 16'(mass_time - m0));
		chk("mass erase", 16'(5297 * D), 16'(ecyc));
		chk("mass ignored", 16'h0001, 16'(ign));
	endtask

	// Reset in mid-erase must drop every array control at once
	task automatic t_abort();
		@(posedge CLK);
		OP_REQ <= 1'b1;
		OP_CMD <= '{op: FPT_OP_MASS_ERASE, last_idx: 6'h00};
		@(posedge CLK);
		OP_REQ <= 1'b0;
		repeat (5) @(posedge CLK);
		SYS_RST <= 1'b1;
		repeat (2) @(posedge CLK);
		SYS_RST <= 1'b0;
		@(negedge CLK);
		chk("abort busy", 16'h0000, {15'h0000, BUSY});
		chk("abort ctrl", 16'h0000, {13'h0000, ARRAY_CTRL});
		@(negedge CLK);
		chk("abort done", 16'h0000, {15'h0000, DONE});
		chk("abort idle", 16'h0000, {15'h0000, BUSY});
	endtask

	initial begin
		repeat (8) @(posedge CLK);
		SYS_RST <= 1'b0;
		t_word();
		t_block(1);
		t_block(64);
		t_seg();
		t_mass();
		t_abort();
		t_word();
		results();
	end

	initial begin
		repeat (40000) @(posedge CLK);
		mismatches++;
		results();
	end
endmodule
